// ---- rtl/clr_top.v ----
// Replacement state store, event selection and refill timing.
// Assumes an APB master, the core on pclk and a one-line memory port.
`default_nettype none
`include "clr_regs.vh"
module clr_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire p0_hit,
	input wire p0_miss,
	input wire p0_write,
	input wire p0_dirty,
	input wire [`CLR_SET_W-1:0] p0_set,
	input wire [2:0] p0_way,
	input wire p1_hit,
	input wire p1_miss,
	input wire p1_write,
	input wire p1_dirty,
	input wire [`CLR_SET_W-1:0] p1_set,
	input wire [2:0] p1_way,
	output wire [2:0] p0_victim,
	output wire [2:0] p1_victim,
	input wire pf_req,
	input wire pf_hit,
	input wire ic_miss,
	input wire ic_stall,
	input wire bank_conflict,
	input wire cb_buf_full,
	input wire stream_miss,
	output wire dc_stall,
	output wire mpi_rd_req,
	input wire mpi_rd_beat,
	input wire mpi_cwf,
	output wire mpi_wr_req,
	input wire mpi_wr_beat,
	output wire timer_source_one,
	output wire timer_source_two
);
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_WAIT = 4'b0010;
	localparam [3:0] S_FILL = 4'b0100;
	localparam [3:0] S_CB = 4'b1000;

	integer i;
	reg [`CLR_LRU_W-1:0] lru_ff [0:`CLR_SETS-1];
	wire [`CLR_LRU_W-1:0] st0;
	wire [`CLR_LRU_W-1:0] st1;
	wire [`CLR_LRU_W-1:0] m0;
	wire [`CLR_LRU_W-1:0] v0;
	wire [`CLR_LRU_W-1:0] m1;
	wire [`CLR_LRU_W-1:0] v1;
	wire [2:0] vic0;
	wire [2:0] vic1;
	reg [2:0] p0_victim_ff;
	reg [2:0] p1_victim_ff;

	reg [3:0] first_event_select_ff;
	reg [3:0] second_event_select_ff;
	reg [`CLR_SET_W-1:0] lru_idx_ff;
	reg [31:0] prdata_ff;
	reg [31:0] nxt_prdata;
	reg pready_ff;
	reg pslverr_ff;
	reg nxt_pslverr;
	wire setup;
	wire wr_en;

	reg [3:0] st_ff;
	reg [3:0] nxt_st;
	reg [4:0] beat_ff;
	reg [4:0] nxt_beat;
	reg [4:0] wait_ff;
	reg [4:0] nxt_wait;
	reg [4:0] last_wait_ff;
	reg [4:0] nxt_last_wait;
	reg demand_ff;
	reg nxt_demand;
	reg rel_ff;
	reg nxt_rel;
	reg cwf_ff;
	reg nxt_cwf;
	reg dirty_ff;
	reg nxt_dirty;
	reg [1:0] pf_cnt_ff;
	reg [1:0] nxt_pf_cnt;
	reg rd_req_ff;
	reg nxt_rd_req;
	reg wr_req_ff;
	reg nxt_wr_req;
	reg dc_stall_ff;
	reg nxt_dc_stall;
	reg cb_start;
	reg wblk_ff;

	wire miss_any;
	wire miss_wr;
	wire miss_take;
	wire pf_take;
	wire wmiss_pres;
	wire [15:0] ev;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign p0_victim = p0_victim_ff;
	assign p1_victim = p1_victim_ff;
	assign dc_stall = dc_stall_ff;
	assign mpi_rd_req = rd_req_ff;
	assign mpi_wr_req = wr_req_ff;

	// Replacement state per port; misses read it, hits only write
	assign st0 = lru_ff[p0_set];
	assign st1 = lru_ff[p1_set];

	clr_lru_port u_port0 (
		.lru_in(st0),
		.hit(p0_hit),
		.miss(p0_miss),
		.way(p0_way),
		.wr_mask(m0),
		.wr_val(v0),
		.victim(vic0)
	);

	clr_lru_port u_port1 (
		.lru_in(st1),
		.hit(p1_hit),
		.miss(p1_miss),
		.way(p1_way),
		.wr_mask(m1),
		.wr_val(v1),
		.victim(vic1)
	);

	// Port one's mask overrides port zero's on shared bits
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (i = 0; i < `CLR_SETS; i = i + 1)
				lru_ff[i] <= `CLR_LRU_RST;
		end
		else
		begin
			for (i = 0; i < `CLR_SETS; i = i + 1)
			begin
				if (p0_set == i[`CLR_SET_W-1:0] && p1_set == i[`CLR_SET_W-1:0])
					lru_ff[i] <= (lru_ff[i] & ~m0 & ~m1) | (v0 & m0 & ~m1) | (v1 & m1);
				else if (p0_set == i[`CLR_SET_W-1:0])
					lru_ff[i] <= (lru_ff[i] & ~m0) | (v0 & m0);
				else if (p1_set == i[`CLR_SET_W-1:0])
					lru_ff[i] <= (lru_ff[i] & ~m1) | (v1 & m1);
			end
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			p0_victim_ff <= 3'h0;
			p1_victim_ff <= 3'h0;
		end
		else
		begin
			if (p0_miss)
				p0_victim_ff <= vic0;
			if (p1_miss)
				p1_victim_ff <= vic1;
		end
	end

	// APB slave, no wait state; pready rises in the first access cycle and read data leaves a flop
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;

	always @*
	begin
		nxt_prdata = 32'h0;
		nxt_pslverr = 1'b0;
		case (paddr)
		`CLR_OFF_EVSEL:
		begin
			nxt_prdata[`CLR_EV1_LSB+3:`CLR_EV1_LSB] = first_event_select_ff;
			nxt_prdata[`CLR_EV2_LSB+3:`CLR_EV2_LSB] = second_event_select_ff;
		end
		`CLR_OFF_LRUIDX:
			nxt_prdata[`CLR_SET_W-1:0] = lru_idx_ff;
		`CLR_OFF_LRUDAT:
			nxt_prdata[`CLR_LRU_W-1:0] = lru_ff[lru_idx_ff];
		`CLR_OFF_REFILL:
		begin
			nxt_prdata[4:0] = last_wait_ff;
			nxt_prdata[`CLR_BUSY_BIT] = ~st_ff[0];
			nxt_prdata[`CLR_STALL_BIT] = dc_stall_ff;
		end
		default:
			nxt_pslverr = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h0;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			first_event_select_ff <= 4'h0;
			second_event_select_ff <= 4'h0;
			lru_idx_ff <= {`CLR_SET_W{1'b0}};
		end
		else
		begin
			pready_ff <= setup;
			pslverr_ff <= setup & nxt_pslverr;
			prdata_ff <= (setup & ~pwrite) ? nxt_prdata : 32'h0;
			if (wr_en && paddr == `CLR_OFF_EVSEL)
			begin
				first_event_select_ff <= pwdata[`CLR_EV1_LSB+3:`CLR_EV1_LSB];
				second_event_select_ff <= pwdata[`CLR_EV2_LSB+3:`CLR_EV2_LSB];
			end
			if (wr_en && paddr == `CLR_OFF_LRUIDX)
				lru_idx_ff <= pwdata[`CLR_SET_W-1:0];
		end
	end

	// Single fetch unit; port zero wins when both ports miss
	assign miss_any = p0_miss | p1_miss;
	assign miss_wr = p0_miss ? p0_write : p1_write;
	assign miss_take = st_ff[0] & miss_any;
	assign pf_take = pf_req & ~pf_hit & st_ff[0] & ~miss_any;
	assign wmiss_pres = (p0_miss & p0_write) | (p1_miss & p1_write);

	always @*
	begin
		nxt_st = st_ff;
		nxt_beat = beat_ff;
		nxt_wait = wait_ff;
		nxt_last_wait = last_wait_ff;
		nxt_demand = demand_ff;
		nxt_rel = rel_ff;
		nxt_cwf = cwf_ff;
		nxt_dirty = dirty_ff;
		nxt_rd_req = rd_req_ff;
		nxt_wr_req = wr_req_ff;
		cb_start = 1'b0;
		if (wait_ff != 5'h1f)
			nxt_wait = wait_ff + 5'd1;
		case (st_ff)
		S_IDLE:
		begin
			if (miss_take || pf_take)
			begin
				nxt_st = S_WAIT;
				nxt_demand = miss_take;
				nxt_dirty = miss_take & (p0_miss ? p0_dirty : p1_dirty);
				nxt_wait = 5'd0;
				nxt_rel = 1'b0;
				nxt_rd_req = 1'b1;
			end
		end
		S_WAIT:
		begin
			if (mpi_rd_beat)
			begin
				nxt_st = S_FILL;
				nxt_beat = 5'd1;
				nxt_cwf = mpi_cwf;
				nxt_rd_req = 1'b0;
			end
		end
		S_FILL:
		begin
			// Critical word lets the core go, but never before the floor
			if (cwf_ff && wait_ff >= `CLR_MIN_WAIT - 5'd1)
				nxt_rel = 1'b1;
			if (mpi_rd_beat)
				nxt_beat = beat_ff + 5'd1;
			if (mpi_rd_beat && beat_ff == `CLR_LINE_BEATS - 5'd1)
			begin
				nxt_last_wait = wait_ff;
				nxt_beat = 5'd0;
				nxt_demand = 1'b0;
				if (dirty_ff)
				begin
					nxt_st = S_CB;
					nxt_wr_req = 1'b1;
					cb_start = 1'b1;
				end
				else
					nxt_st = S_IDLE;
			end
		end
		S_CB:
		begin
			if (mpi_wr_beat)
				nxt_beat = beat_ff + 5'd1;
			if (mpi_wr_beat && beat_ff == `CLR_LINE_BEATS - 5'd1)
			begin
				nxt_st = S_IDLE;
				nxt_beat = 5'd0;
				nxt_wr_req = 1'b0;
			end
		end
		default:
			nxt_st = S_IDLE;
		endcase
		if (pf_take)
			nxt_pf_cnt = `CLR_PF_STALL;
		else if (pf_cnt_ff != 2'd0)
			nxt_pf_cnt = pf_cnt_ff - 2'd1;
		else
			nxt_pf_cnt = 2'd0;
		// A held miss while busy stalls the core; copyback does not
		nxt_dc_stall = ((nxt_st == S_WAIT || nxt_st == S_FILL) && nxt_demand && !nxt_rel)
			|| (nxt_pf_cnt != 2'd0) || (miss_any && !st_ff[0]);
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_ff <= S_IDLE;
			beat_ff <= 5'd0;
			wait_ff <= 5'd0;
			last_wait_ff <= 5'd0;
			demand_ff <= 1'b0;
			rel_ff <= 1'b0;
			cwf_ff <= 1'b0;
			dirty_ff <= 1'b0;
			pf_cnt_ff <= 2'd0;
			rd_req_ff <= 1'b0;
			wr_req_ff <= 1'b0;
			dc_stall_ff <= 1'b0;
			wblk_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			beat_ff <= nxt_beat;
			wait_ff <= nxt_wait;
			last_wait_ff <= nxt_last_wait;
			demand_ff <= nxt_demand;
			rel_ff <= nxt_rel;
			cwf_ff <= nxt_cwf;
			dirty_ff <= nxt_dirty;
			pf_cnt_ff <= nxt_pf_cnt;
			rd_req_ff <= nxt_rd_req;
			wr_req_ff <= nxt_wr_req;
			dc_stall_ff <= nxt_dc_stall;
			wblk_ff <= wmiss_pres & ~st_ff[0];
		end
	end

	// Event vector; two misses in one cycle count as one unit
	assign ev[`CLR_EV_NONE] = 1'b0;
	assign ev[`CLR_EV_IMISS] = ic_miss;
	assign ev[`CLR_EV_ISTALL] = ic_stall;
	assign ev[`CLR_EV_BANK] = bank_conflict;
	assign ev[`CLR_EV_RMISS] = miss_take & ~miss_wr;
	assign ev[`CLR_EV_WMISS] = miss_take & miss_wr;
	assign ev[`CLR_EV_DSTALL] = dc_stall_ff & ~ic_stall;
	assign ev[`CLR_EV_CB] = cb_start;
	assign ev[`CLR_EV_CBFULL] = cb_buf_full;
	assign ev[`CLR_EV_WMBUSY] = wmiss_pres & ~st_ff[0] & ~wblk_ff;
	assign ev[`CLR_EV_STREAM] = stream_miss;
	assign ev[`CLR_EV_PFKEEP] = pf_take;
	assign ev[`CLR_EV_PFDROP] = pf_req & ~pf_take;
	assign ev[`CLR_EV_PFHIT] = pf_req & pf_hit;
	assign ev[`CLR_EV_RSV0] = 1'b0;
	assign ev[`CLR_EV_RSV1] = 1'b0;

	clr_event_mux u_ev_one (
		.pclk(pclk),
		.presetn(presetn),
		.sel(first_event_select_ff),
		.ev(ev),
		.strobe_ff(timer_source_one)
	);

	clr_event_mux u_ev_two (
		.pclk(pclk),
		.presetn(presetn),
		.sel(second_event_select_ff),
		.ev(ev),
		.strobe_ff(timer_source_two)
	);
endmodule // clr_top
`default_nettype wire

// ---- inc/clr_regs.vh ----
// Constants for the cache replacement-state and event-select block.
// Assumes one clock domain and an APB master with 12-bit byte addresses.
// Contract
// - Reset loads legal replacement state per set
// - Ten state bits per set, readable by software
// - Two same-set accesses update in one cycle
// - Bit changed by one port follows algorithm
// - Bit changed by both: port zero, then one
// - Two independent selectors drive two timer sources
// - Codes 0-3: none, imiss, istall, bank conflict
// - Codes 4-7: rmiss, wmiss, dstall only, copyback
// - Codes 8-10: cbfull, wmiss busy, stream miss
// - Codes 11-13: prefetch kept/dropped/hit; 14-15 reserved
// - Read miss waits at least twelve cycles
// - Line refill is sixteen transfer cycles
// - Write miss fetches line like read miss
// - Dirty victim copied back after refill, unstalled
// - Prefetch like miss, droppable, three stall cycles
// - Pair bits 9:6, matrix bits 5:0 layout
// - Even hit sets pair bit; bit picks victim
// - Reference sets row, clears column; pick LRU
// - Element j updates pair j/2, bit j%2
`ifndef CLR_REGS_VH
`define CLR_REGS_VH
`define CLR_SET_W 6
`define CLR_SETS 64
`define CLR_LRU_W 10
`define CLR_LRU_RST 10'h029
`define CLR_PAIR_LSB 6
`define CLR_OFF_EVSEL 12'h000
`define CLR_OFF_LRUIDX 12'h004
`define CLR_OFF_LRUDAT 12'h008
`define CLR_OFF_REFILL 12'h00c
`define CLR_EV1_LSB 0
`define CLR_EV2_LSB 4
`define CLR_BUSY_BIT 8
`define CLR_STALL_BIT 9
`define CLR_MIN_WAIT 5'd12
`define CLR_LINE_BEATS 5'd16
`define CLR_PF_STALL 2'd3
`define CLR_EV_NONE 0
`define CLR_EV_IMISS 1
`define CLR_EV_ISTALL 2
`define CLR_EV_BANK 3
`define CLR_EV_RMISS 4
`define CLR_EV_WMISS 5
`define CLR_EV_DSTALL 6
`define CLR_EV_CB 7
`define CLR_EV_CBFULL 8
`define CLR_EV_WMBUSY 9
`define CLR_EV_STREAM 10
`define CLR_EV_PFKEEP 11
`define CLR_EV_PFDROP 12
`define CLR_EV_PFHIT 13
`define CLR_EV_RSV0 14
`define CLR_EV_RSV1 15
`endif

// ---- rtl/clr_lru_port.v ----
// One port's replacement-state write mask, values and victim.
// Assumes the caller merges the masks of both ports.
`default_nettype none
`include "clr_regs.vh"
module clr_lru_port (
	input wire [`CLR_LRU_W-1:0] lru_in,
	input wire hit,
	input wire miss,
	input wire [2:0] way,
	output reg [`CLR_LRU_W-1:0] wr_mask,
	output reg [`CLR_LRU_W-1:0] wr_val,
	output reg [2:0] victim
);
	reg [1:0] vpair;
	reg [2:0] ref_way;
	always @*
	begin
		// Stored bits only looked at for the victim
		if (!lru_in[5] && lru_in[4] && lru_in[1])
			vpair = 2'd1;
		else if (!lru_in[3] && !lru_in[4] && lru_in[2])
			vpair = 2'd2;
		else if (!lru_in[0] && !lru_in[1] && !lru_in[2])
			vpair = 2'd3;
		else
			vpair = 2'd0;
		victim = {vpair, lru_in[`CLR_PAIR_LSB + vpair]};
		ref_way = hit ? way : victim;
		wr_mask = {`CLR_LRU_W{1'b0}};
		wr_val = {`CLR_LRU_W{1'b0}};
		if (hit || miss)
		begin
			wr_mask[`CLR_PAIR_LSB + ref_way[2:1]] = 1'b1;
			wr_val[`CLR_PAIR_LSB + ref_way[2:1]] = ~ref_way[0];
			case (ref_way[2:1])
			2'd0:
				wr_mask[5:0] = 6'h29;
			2'd1:
			begin
				wr_mask[5:0] = 6'h32;
				wr_val[5:0] = 6'h20;
			end
			2'd2:
			begin
				wr_mask[5:0] = 6'h1c;
				wr_val[5:0] = 6'h18;
			end
			default:
			begin
				wr_mask[5:0] = 6'h07;
				wr_val[5:0] = 6'h07;
			end
			endcase
		end
	end
endmodule // clr_lru_port
`default_nettype wire

// ---- rtl/clr_event_mux.v ----
// One selectable event strobe toward a timer source.
// Assumes event inputs are one-cycle units on the same clock.
`default_nettype none
`include "clr_regs.vh"
module clr_event_mux (
	input wire pclk,
	input wire presetn,
	input wire [3:0] sel,
	input wire [15:0] ev,
	output reg strobe_ff
);
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strobe_ff <= 1'b0;
		else
			strobe_ff <= ev[sel];
	end
endmodule // clr_event_mux
`default_nettype wire

// ---- tb/clr_assertions.sv ----
// Checker on the ports of the replacement-state block.
// Assumes one pclk domain and a memory side sending 16 beats a line.
`default_nettype none
`include "clr_regs.vh"
module clr_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic p0_miss,
	input wire logic p1_miss,
	input wire logic [2:0] p0_victim,
	input wire logic pf_req,
	input wire logic pf_hit,
	input wire logic dc_stall,
	input wire logic mpi_rd_req,
	input wire logic mpi_rd_beat,
	input wire logic mpi_cwf,
	input wire logic mpi_wr_req,
	input wire logic timer_source_one,
	input wire logic timer_source_two
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] rd_cnt;
	logic [4:0] st_cnt;
	logic cwf_seen;
	wire logic busy;
	// Beats still due count as busy even after the request drops
	assign busy = mpi_rd_req || mpi_wr_req || (rd_cnt != 0 && rd_cnt != 16);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_cnt <= 0;
			st_cnt <= 0;
			cwf_seen <= 0;
		end
		else
		begin
			if (mpi_rd_req && rd_cnt == 16)
				rd_cnt <= 0;
			else if (mpi_rd_beat)
				rd_cnt <= rd_cnt + 5'd1;
			if (mpi_rd_beat && rd_cnt == 0)
				cwf_seen <= mpi_cwf;
			st_cnt <= !dc_stall ? 5'd0 : (st_cnt == 31) ? st_cnt : st_cnt + 5'd1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_pf_pen;
		dc_stall [*3] ##1 !dc_stall;
	endsequence
	a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
		else $error("register access answer timing wrong");
	a_miss_fetch: assert property ((p0_miss || p1_miss) && !busy && !dc_stall |=> mpi_rd_req && dc_stall)
		else $error("miss did not start a line fetch");
	a_fill_len: assert property ($fell(dc_stall) && rd_cnt != 0 && !cwf_seen |-> rd_cnt == 16)
		else $error("stall ended before sixteen beats");
	a_wait_floor: assert property ($fell(dc_stall) && rd_cnt != 0 |-> st_cnt >= 10)
		else $error("miss wait too short");
	a_copy_after: assert property ($rose(mpi_wr_req) |-> $past(mpi_rd_beat) && !dc_stall)
		else $error("copyback not right after fill or stalled");
	a_pf_keep: assert property (pf_req && !pf_hit && !busy && !dc_stall && !p0_miss && !p1_miss |=> s_pf_pen)
		else $error("prefetch stall not three cycles");
	a_pf_drop: assert property (pf_req && pf_hit && !busy && !dc_stall |=> !mpi_rd_req && !dc_stall)
		else $error("hitting prefetch not dropped");
	a_victim_hold: assert property (!p0_miss |=> $stable(p0_victim))
		else $error("victim changed without a miss");
	a_reset_quiet: assert property ($rose(presetn) |-> !dc_stall && !mpi_rd_req && !timer_source_one && !timer_source_two && p0_victim == 0)
		else $error("outputs not quiet after reset");
endmodule // clr_assertions
bind clr_top clr_assertions chk_i (.pclk, .presetn, .psel, .penable, .pready, .p0_miss, .p1_miss,
	.p0_victim, .pf_req, .pf_hit, .dc_stall, .mpi_rd_req, .mpi_rd_beat, .mpi_cwf, .mpi_wr_req,
	.timer_source_one, .timer_source_two);
`default_nettype wire

// ---- tb/clr_mem_model.sv ----
// Memory port model: answers line fetches and copybacks.
// Assumes one request at a time; latency alternates short and long.
`default_nettype none
module clr_mem_model (
	input wire logic pclk,
	input wire logic mpi_rd_req,
	input wire logic mpi_wr_req,
	input wire logic cwf_en,
	output logic mpi_rd_beat,
	output logic mpi_cwf,
	output logic mpi_wr_beat,
	output logic mem_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rd;
	int lat = 3;
	initial
	begin
		{mpi_rd_beat, mpi_cwf, mpi_wr_beat, mem_busy} = 4'h0;
		forever
		begin
			@(posedge pclk);
			if (mpi_rd_req === 1'b1 || mpi_wr_req === 1'b1)
			begin
				rd = mpi_rd_req;
				mem_busy <= 1'b1;
				repeat (lat) @(posedge pclk);
				lat = 9 - lat;
				// Line is 16 beats of 4 bytes
				for (int i = 0; i < 16; i++)
				begin
					mpi_rd_beat <= rd;
					mpi_wr_beat <= !rd;
					mpi_cwf <= rd && cwf_en && i == 0;
					@(posedge pclk);
				end
				{mpi_rd_beat, mpi_cwf, mpi_wr_beat, mem_busy} <= 4'h0;
			end
		end
	end
endmodule // clr_mem_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench: replacement state, misses, prefetch and event strobes.
// Assumes the memory model on the fill and copyback side.
`default_nettype none
`include "clr_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, cwf_en = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd;
	logic p0_hit = 0, p0_miss = 0, p0_write = 0, p0_dirty = 0, pf_req = 0, pf_hit = 0;
	logic p1_hit = 0, p1_miss = 0, p1_write = 0, p1_dirty = 0;
	logic [5:0] p0_set = 0, p1_set = 0;
	logic [2:0] p0_way = 0, p1_way = 0;
	logic [4:0] evs = 0;
	wire logic [31:0] prdata;
	wire logic [2:0] p0_victim, p1_victim;
	wire logic pready, pslverr, dc_stall, mpi_rd_req, mpi_rd_beat, mpi_cwf, mpi_wr_req;
	wire logic mpi_wr_beat, timer_source_one, timer_source_two, mem_busy;
	logic [9:0] lru [64];
	int err_total = 0, checked = 0;
	int codes [7] = '{1, 2, 3, 8, 10, 11, 13};
	int t2_cnt = 0;
	always #2 pclk = ~pclk;
	// Units seen on the second timer source, one per high cycle
	always @(posedge pclk)
	begin
		if (timer_source_two === 1'b1)
			t2_cnt++;
	end
	clr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .p0_hit, .p0_miss, .p0_write, .p0_dirty, .p0_set, .p0_way, .p1_hit, .p1_miss,
		.p1_write, .p1_dirty, .p1_set, .p1_way, .p0_victim, .p1_victim, .pf_req, .pf_hit,
		.ic_miss(evs[0]), .ic_stall(evs[1]), .bank_conflict(evs[2]), .cb_buf_full(evs[3]),
		.stream_miss(evs[4]), .dc_stall, .mpi_rd_req, .mpi_rd_beat, .mpi_cwf, .mpi_wr_req,
		.mpi_wr_beat, .timer_source_one, .timer_source_two);
	clr_mem_model mem (.pclk, .mpi_rd_req, .mpi_wr_req, .cwf_en, .mpi_rd_beat, .mpi_cwf,
		.mpi_wr_beat, .mem_busy);
	function automatic int pos(input int a, input int b);
		return (a == 3) ? b : (a == 2) ? 3 + b : 5;
	endfunction
	function automatic logic [9:0] upd(input logic [9:0] s, input int j);
		int m;
		m = j / 2;
		s[6 + m] = ~j[0];
		for (int a = 1; a < 4; a++)
			for (int b = 0; b < a; b++)
			begin
				if (a == m) s[pos(a, b)] = 1'b1;
				if (b == m) s[pos(a, b)] = 1'b0;
			end
		return s;
	endfunction
	function automatic int vic(input logic [9:0] s);
		int p, ok;
		p = 0;
		for (int k = 0; k < 4; k++)
		begin
			ok = 1;
			for (int a = 1; a < 4; a++)
				for (int b = 0; b < a; b++)
					if ((a == k && s[pos(a, b)]) || (b == k && !s[pos(a, b)])) ok = 0;
			if (ok) p = k;
		end
		return 2 * p + s[6 + p];
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (int i = 0; i <= 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1) break;
			if (i == 20)
			begin
				err_total++;
				conclude();
			end
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdset(input logic [5:0] s);
		apb(1, `CLR_OFF_LRUIDX, {26'h0, s});
		apb(0, `CLR_OFF_LRUDAT, 0);
		chk(rd, {22'h0, lru[s]});
	endtask
	task automatic idle();
		repeat (2) @(posedge pclk);
		for (int i = 0; i <= 300; i++)
		begin
			@(posedge pclk);
			if (!mem_busy && !dc_stall && !mpi_rd_req && !mpi_wr_req) break;
			if (i == 300)
			begin
				err_total++;
				conclude();
			end
		end
	endtask
	task automatic ev(input logic [3:0] c1, input logic [3:0] c2, input int src, input logic [1:0] e);
		apb(1, `CLR_OFF_EVSEL, {24'h0, c2, c1});
		@(posedge pclk);
		if (src < 5) evs[src] <= 1;
		pf_req <= src > 4;
		pf_hit <= src == 6;
		@(posedge pclk);
		evs <= 0;
		pf_req <= 0;
		@(posedge pclk);
		chk({timer_source_one, timer_source_two}, e);
		idle();
	endtask
	task automatic miss(input logic pt, input logic wr, input logic dt, input logic cw);
		logic [5:0] s;
		int v;
		int c;
		s = $urandom_range(63, 0);
		cwf_en <= cw;
		apb(1, `CLR_OFF_EVSEL, wr ? 32'h75 : 32'h64);
		c = t2_cnt;
		@(posedge pclk);
		p0_miss <= !pt;
		p1_miss <= pt;
		p0_write <= wr;
		p0_dirty <= dt;
		p0_set <= s;
		p1_set <= s;
		@(posedge pclk);
		p0_miss <= 0;
		p1_miss <= 0;
		@(posedge pclk);
		v = vic(lru[s]);
		chk(pt ? p1_victim : p0_victim, v);
		chk({timer_source_one, timer_source_two}, 2'b10);
		lru[s] = upd(lru[s], v);
		idle();
		chk(t2_cnt - c, dt ? 1 : `CLR_MIN_WAIT);
		rdset(s);
	endtask
	initial
	begin
		void'($urandom(32'h3cd94b17));
		foreach (lru[i]) lru[i] = `CLR_LRU_RST;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		rdset(0);
		rdset(63);
		apb(0, 12'h010, 0);
		chk({er, rd}, {1'b1, 32'h0});
		$display("test reset and map done");
		for (int n = 0; n < 12; n++)
		begin
			@(posedge pclk);
			p0_hit <= 1;
			p0_set <= $urandom_range(1, 0);
			p0_way <= $urandom_range(7, 0);
			p1_hit <= $urandom_range(1, 0);
			p1_set <= $urandom_range(1, 0);
			p1_way <= $urandom_range(7, 0);
			@(posedge pclk);
			p0_hit <= 0;
			p1_hit <= 0;
			lru[p0_set] = upd(lru[p0_set], p0_way);
			if (p1_hit) lru[p1_set] = upd(lru[p1_set], p1_way);
			rdset(p0_set);
		end
		$display("test hits done");
		miss(0, 1, 1, 0);
		miss(1, 0, 0, 1);
		$display("test misses done");
		for (int s = 0; s < 7; s++)
		begin
			ev(codes[s], 15, s, 2'b10);
			ev(14, codes[s], s, 2'b01);
		end
		ev(11, 12, 5, 2'b10);
		ev(12, 0, 6, 2'b10);
		ev(0, 0, 2, 2'b00);
		$display("test events done");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
